// >>> shared/afl_pkg.sv
package afl_pkg;
	// Process quantities in tenths of a unit, signed
	localparam int VAL_W = 16;
	typedef logic signed [VAL_W-1:0] afl_val_t;

	typedef enum logic [3:0] {
		FN_NONE,
		FN_IN1_HIGH, FN_IN1_LOW, FN_IN2_HIGH, FN_IN2_LOW,
		FN_EITHER_HIGH, FN_EITHER_LOW, FN_DIFF_HIGH, FN_DIFF_LOW,
		FN_OFFSET_HIGH, FN_OFFSET_LOW, FN_BAND_HIGH, FN_BAND_LOW,
		FN_DWELL_TIMER, FN_LOOP_FAILURE
	} afl_func_e;

	typedef enum logic [1:0] {
		MODE_PLAIN, MODE_LATCHED, MODE_HOLD, MODE_LATCHED_INHIBIT
	} afl_mode_e;

	// Settings of one alarm channel
	typedef struct packed {
		afl_func_e func;
		afl_mode_e mode;
		afl_val_t  level;
		afl_val_t  deviation;
		afl_val_t  hysteresis;
	} afl_chan_cfg_s;

	// Measurements shared by both channels
	typedef struct packed {
		afl_val_t   pv1;
		afl_val_t   pv2;
		afl_val_t   setpoint;
		logic [9:0] mvLevel;
	} afl_proc_s;

	// Control output limits, tenths of a percent
	localparam logic [9:0] MV_MAX = 10'h3e8;
	localparam logic [9:0] MV_MIN = 10'h000;

	// Dwell time: 16-bit count of tenths of a minute, max 6553.5 min
	localparam int DWELL_W = 16;
	// Tick period that clocks the alarm timers
	localparam int  TICK_MS = 100;
	localparam int  CLK_HZ = 20000000;
	localparam int  TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// One tenth minute is 60 ticks of 100 ms
	localparam int  TICKS_PER_TENTH_MIN = 60;
	// Loop break window cap, seconds; integral time in seconds
	localparam int  LB_MAX_S = 120;
	localparam int  TICKS_PER_S = 10;
	localparam int  LB_W = 12;
	localparam logic [LB_W-1:0] LB_MAX_TICKS = LB_W'(LB_MAX_S * TICKS_PER_S);
endpackage

// >>> rtl/afl_alarm_channel.sv
`timescale 1ns/1ps
module afl_alarm_channel (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Configuration and measurements
	input  wire afl_pkg::afl_chan_cfg_s cfg,
	input  wire afl_pkg::afl_proc_s     proc,
	input  wire logic                   loopAllowed,
	input  wire logic                   latchClear,
	input  wire logic                   tick,
	input  wire logic                   spReached,
	input  wire logic [7:0]             integralTime,
	input  wire logic [15:0]            dwellTime,
	// Result
	output logic                        alarmOut
);
	import afl_pkg::*;

	typedef struct packed {
		logic             cond;
		logic             out;
		logic             armed;
		logic             dwellRun;
		logic             dwellDone;
		logic [DWELL_W-1:0] dwellCnt;
		logic [5:0]       subCnt;
		logic [LB_W-1:0]  lbCnt;
		afl_val_t         lbStart;
		logic             lbSat;
		logic             lbHigh;
	} afl_ch_state_s;

	afl_ch_state_s st;
	afl_ch_state_s next_st;

	logic signed [VAL_W+1:0] diffVal;
	logic signed [VAL_W+1:0] upper;
	logic signed [VAL_W+1:0] lower;
	logic signed [VAL_W+1:0] bandHi;
	logic signed [VAL_W+1:0] bandLo;
	logic signed [VAL_W+1:0] v1;
	logic signed [VAL_W+1:0] v2;
	logic [LB_W-1:0]         lbWindow;
	logic [LB_W+1:0]         lbRaw;
	logic                    atLimit;
	logic                    isHold;
	logic                    isLatch;

	always_comb begin
		v1 = (VAL_W+2)'(proc.pv1);
		v2 = (VAL_W+2)'(proc.pv2);
		diffVal = v1 - v2;
		// Process alarms use absolute level, offset ones track the set point
		if (cfg.func inside {FN_OFFSET_HIGH, FN_OFFSET_LOW}) begin
			upper = (VAL_W+2)'(proc.setpoint) + (VAL_W+2)'(cfg.deviation);
		end else begin
			upper = (VAL_W+2)'(cfg.level);
		end
		lower = upper - (VAL_W+2)'(cfg.hysteresis);
		upper = upper + (VAL_W+2)'(cfg.hysteresis);
		bandHi = (VAL_W+2)'(proc.setpoint) + (VAL_W+2)'(cfg.deviation);
		bandLo = (VAL_W+2)'(proc.setpoint) - (VAL_W+2)'(cfg.deviation);
		lbRaw = {5'h0, integralTime, 1'b0} * (LB_W+2)'(TICKS_PER_S);
		lbWindow = (lbRaw > (LB_W+2)'(LB_MAX_TICKS)) ? LB_MAX_TICKS : lbRaw[LB_W-1:0];
		atLimit = (proc.mvLevel == MV_MAX) || (proc.mvLevel == MV_MIN);
		isHold = cfg.mode inside {MODE_HOLD, MODE_LATCHED_INHIBIT};
		isLatch = cfg.mode inside {MODE_LATCHED, MODE_LATCHED_INHIBIT};

		next_st = st;
		// Hysteresis: assert past upper, clear past lower (mirrored for low)
		unique case (cfg.func)
			FN_IN1_HIGH:    next_st.cond = st.cond ? (v1 > lower) : (v1 > upper);
			FN_IN1_LOW:     next_st.cond = st.cond ? (v1 < upper) : (v1 < lower);
			FN_IN2_HIGH:    next_st.cond = st.cond ? (v2 > lower) : (v2 > upper);
			FN_IN2_LOW:     next_st.cond = st.cond ? (v2 < upper) : (v2 < lower);
			FN_EITHER_HIGH: next_st.cond = st.cond ? (v1 > lower || v2 > lower)
			                                       : (v1 > upper || v2 > upper);
			FN_EITHER_LOW:  next_st.cond = st.cond ? (v1 < upper || v2 < upper)
			                                       : (v1 < lower || v2 < lower);
			FN_DIFF_HIGH:   next_st.cond = st.cond ? (diffVal > lower) : (diffVal > upper);
			FN_DIFF_LOW:    next_st.cond = st.cond ? (diffVal < upper) : (diffVal < lower);
			FN_OFFSET_HIGH: next_st.cond = st.cond ? (v1 > lower) : (v1 > upper);
			FN_OFFSET_LOW:  next_st.cond = st.cond ? (v1 < upper) : (v1 < lower);
			FN_BAND_HIGH:   next_st.cond = (v1 > bandHi) || (v1 < bandLo);
			FN_BAND_LOW:    next_st.cond = (v1 <= bandHi) && (v1 >= bandLo);
			FN_LOOP_FAILURE: next_st.cond = st.cond;
			default:        next_st.cond = 1'b0;
		endcase

		// Loop break: over each window the saturated output must move the process
		if (cfg.func == FN_LOOP_FAILURE && loopAllowed) begin
			if (!atLimit) begin
				next_st.lbSat = 1'b0;
				next_st.lbCnt = '0;
				next_st.cond = 1'b0;
			end else if (!st.lbSat || st.lbHigh != (proc.mvLevel == MV_MAX)) begin
				next_st.lbSat = 1'b1;
				next_st.lbHigh = (proc.mvLevel == MV_MAX);
				next_st.lbCnt = '0;
				next_st.lbStart = proc.pv1;
			end else if (tick) begin
				if (st.lbCnt + 1'b1 >= lbWindow) begin
					// Window end: alarm if no movement in the driven direction
					next_st.cond = st.lbHigh ? (proc.pv1 <= st.lbStart)
					                         : (proc.pv1 >= st.lbStart);
					next_st.lbCnt = '0;
					next_st.lbStart = proc.pv1;
				end else begin
					next_st.lbCnt = st.lbCnt + 1'b1;
				end
			end
		end else if (cfg.func == FN_LOOP_FAILURE) begin
			next_st.cond = 1'b0;
			next_st.lbSat = 1'b0;
		end

		// Holding suppresses until set point first reached; loop break skips it
		if (spReached || !isHold || cfg.func == FN_LOOP_FAILURE) begin
			next_st.armed = 1'b1;
		end

		if (cfg.func == FN_DWELL_TIMER) begin
			// Mode ignored: relay switches once the dwell time runs out, then holds
			if (!st.dwellRun && !st.dwellDone && spReached) begin
				next_st.dwellRun = 1'b1;
				next_st.dwellCnt = '0;
				next_st.subCnt = '0;
			end else if (st.dwellRun && st.dwellCnt >= dwellTime) begin
				next_st.dwellRun = 1'b0;
				next_st.dwellDone = 1'b1;
			end else if (st.dwellRun && tick) begin
				if (st.subCnt == 6'(TICKS_PER_TENTH_MIN - 1)) begin
					next_st.subCnt = '0;
					next_st.dwellCnt = st.dwellCnt + 1'b1;
				end else begin
					next_st.subCnt = st.subCnt + 1'b1;
				end
			end
			next_st.out = st.dwellDone;
		end else begin
			next_st.dwellRun = 1'b0;
			next_st.dwellDone = 1'b0;
			if (!next_st.armed) begin
				next_st.out = 1'b0;
			end else if (isLatch) begin
				// Clear only by event input, and a live condition still wins
				next_st.out = next_st.cond || (st.out && !latchClear);
			end else begin
				next_st.out = next_st.cond;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign alarmOut = st.out;

	AST_LATCH_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
		(isLatch && cfg.func != FN_DWELL_TIMER && st.out && !latchClear
		 && $stable(cfg)) |=> st.out)
		else $error("latched alarm dropped");
	AST_PLAIN_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
		(cfg.mode == MODE_PLAIN && cfg.func != FN_DWELL_TIMER && st.armed && $stable(cfg))
		|=> (st.out == st.cond))
		else $error("plain alarm not following condition");
	AST_HOLD_SUPPRESS: assert property (@(posedge clk) disable iff (sys_rst)
		(!st.armed && cfg.func != FN_DWELL_TIMER) |-> !st.out)
		else $error("held alarm energized");
	AST_LOOP_NO_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		(cfg.func == FN_LOOP_FAILURE) |=> st.armed)
		else $error("loop break alarm held");
	AST_DWELL_END: assert property (@(posedge clk) disable iff (sys_rst)
		(cfg.func == FN_DWELL_TIMER && st.dwellRun && st.dwellCnt >= dwellTime
		 && $stable(cfg)) |=> ##1 st.out)
		else $error("dwell relay did not switch");
	AST_LB_WINDOW: assert property (@(posedge clk) disable iff (sys_rst)
		(integralTime >= 8'(LB_MAX_S / 2)) ? (lbWindow == LB_MAX_TICKS)
		: (lbWindow == LB_W'(integralTime) * LB_W'(2 * TICKS_PER_S)))
		else $error("loop window not twice integral time");
	AST_BAND_LOW: assert property (@(posedge clk) disable iff (sys_rst)
		(cfg.func == FN_BAND_LOW && v1 < bandLo) |=> !st.cond)
		else $error("band low outside band");
	AST_DIFF_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
		(cfg.func == FN_DIFF_HIGH && !st.cond && diffVal > upper) |=> st.cond)
		else $error("difference alarm missed");
endmodule

// >>> rtl/afl_alarm_logic.sv
`timescale 1ns/1ps
module afl_alarm_logic (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Channel settings
	input  wire afl_pkg::afl_chan_cfg_s alarm1Cfg,
	input  wire afl_pkg::afl_chan_cfg_s alarm2Cfg,
	input  wire logic                   output2AlarmDuty,
	input  wire logic [15:0]            dwellTime,
	input  wire logic [7:0]             integralTime,
	// Event input, already qualified by its function setting
	input  wire logic                   eventLatchClear,
	// Measurements
	input  wire afl_pkg::afl_proc_s     proc,
	// Results
	output logic                        alarm1Out,
	output logic                        alarm2Out,
	output logic                        configError
);
	import afl_pkg::*;

	typedef struct packed {
		logic [21:0] tickCnt;
		logic        tick;
		logic        spReached;
		logic        cfgErr;
		logic        a1;
		logic        a2;
	} afl_top_state_s;

	afl_top_state_s st;
	afl_top_state_s next_st;
	logic           ch1Raw;
	logic           ch2Raw;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.tickCnt == 22'(TICK_CYCLES - 1)) begin
			next_st.tickCnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.tickCnt = st.tickCnt + 1'b1;
		end
		// Sticky from first arrival at set point until reset (power cycle)
		if (proc.pv1 >= proc.setpoint) begin
			next_st.spReached = 1'b1;
		end
		next_st.cfgErr = (alarm1Cfg.func == FN_DWELL_TIMER)
		              && (alarm2Cfg.func == FN_DWELL_TIMER);
		next_st.a1 = ch1Raw;
		next_st.a2 = output2AlarmDuty && ch2Raw;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	afl_alarm_channel uCh1 (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.cfg          (alarm1Cfg),
		.proc         (proc),
		.loopAllowed  (1'b1),
		.latchClear   (eventLatchClear),
		.tick         (st.tick),
		.spReached    (st.spReached),
		.integralTime (integralTime),
		.dwellTime    (dwellTime),
		.alarmOut     (ch1Raw)
	);

	afl_alarm_channel uCh2 (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.cfg          (alarm2Cfg),
		.proc         (proc),
		.loopAllowed  (output2AlarmDuty),
		.latchClear   (eventLatchClear),
		.tick         (st.tick),
		.spReached    (st.spReached),
		.integralTime (integralTime),
		.dwellTime    (dwellTime),
		.alarmOut     (ch2Raw)
	);

	assign alarm1Out = st.a1;
	assign alarm2Out = st.a2;
	assign configError = st.cfgErr;

	AST_CFG_ERR: assert property (@(posedge clk) disable iff (sys_rst)
		(alarm1Cfg.func == FN_DWELL_TIMER && alarm2Cfg.func == FN_DWELL_TIMER) |=> configError)
		else $error("dual timer not flagged");
	AST_OUTPUT2_ASSIGNMENT_DUTY: assert property (@(posedge clk) disable iff (sys_rst)
		!output2AlarmDuty |=> !alarm2Out)
		else $error("alarm two active without duty");
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t %s", $time, m); end end
module testbench;
	import afl_pkg::*;
	logic          clk;
	logic          sys_rst;
	afl_chan_cfg_s cf [2];
	afl_proc_s     pr;
	logic          duty;
	logic [15:0]   dwellTime;
	logic [7:0]    integralTime;
	logic          clr;
	logic          alarm1Out;
	logic          alarm2Out;
	logic          configError;
	int            miscompares;
	int            n_tests;
	bit            mc [2];
	bit            ml [2];
	bit            sps;
	int            k;

	afl_alarm_logic u_dut (
		.clk(clk), .sys_rst(sys_rst), .alarm1Cfg(cf[0]), .alarm2Cfg(cf[1]),
		.output2AlarmDuty(duty), .dwellTime(dwellTime), .integralTime(integralTime),
		.eventLatchClear(clr), .proc(pr), .alarm1Out(alarm1Out), .alarm2Out(alarm2Out),
		.configError(configError)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic afl_val_t rv(input int span);
		return afl_val_t'(int'($urandom_range(2 * span)) - span);
	endfunction

	// Condition model; either-input uses the extreme value so set is "any", clear is "all"
	function automatic bit cond(input afl_chan_cfg_s c, input bit prev);
		int a, b, lv, h, sp, d;
		bit hi;
		a = pr.pv1;
		b = pr.pv2;
		sp = pr.setpoint;
		lv = c.level;
		h = c.hysteresis;
		d = c.deviation;
		hi = c.func inside {FN_IN1_HIGH, FN_IN2_HIGH, FN_EITHER_HIGH, FN_DIFF_HIGH, FN_OFFSET_HIGH};
		case (c.func)
			FN_IN2_HIGH, FN_IN2_LOW: a = b;
			FN_EITHER_HIGH: a = (a > b) ? a : b;
			FN_EITHER_LOW: a = (a < b) ? a : b;
			FN_DIFF_HIGH, FN_DIFF_LOW: a = a - b;
			FN_OFFSET_HIGH, FN_OFFSET_LOW: lv = sp + d;
			FN_BAND_HIGH: return (a > sp + d) || (a < sp - d);
			FN_BAND_LOW: return (a >= sp - d) && (a <= sp + d);
			default: ;
		endcase
		if (hi)
			return (a > lv + h) ? 1'b1 : ((a <= lv - h) ? 1'b0 : prev);
		return (a < lv - h) ? 1'b1 : ((a >= lv + h) ? 1'b0 : prev);
	endfunction

	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		mc = '{0, 0};
		ml = '{0, 0};
		sps = 1'b0;
		// Return in the release step: the first edge out of reset must already see fresh
		// stimulus, or stale values could latch or arm a channel unseen by the model
	endtask

	// Inputs stay put for four cycles, past the answer of at most three cycles (set point arming)
	task automatic settle(input string nm);
		bit en;
		bit ex [2];
		repeat (4) @(posedge clk);
		#1;
		sps |= (pr.pv1 >= pr.setpoint);
		for (int i = 0; i < 2; i++) begin
			mc[i] = cond(cf[i], mc[i]);
			en = !(cf[i].mode inside {MODE_HOLD, MODE_LATCHED_INHIBIT}) || sps;
			if (cf[i].mode inside {MODE_LATCHED, MODE_LATCHED_INHIBIT})
				ml[i] = (mc[i] && en) ? 1'b1 : (clr ? 1'b0 : ml[i]);
			else
				ml[i] = mc[i] && en;
			ex[i] = ml[i] && (i == 0 || duty);
		end
		`CHK(alarm1Out, logic'(ex[0]), nm)
		`CHK(alarm2Out, logic'(ex[1]), nm)
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		int vals [7] = '{105, 106, 96, 95, 94, 104, 105};
		miscompares = 0;
		n_tests = 0;
		cf[0] = '0;
		cf[1] = '0;
		pr = '0;
		duty = 1'b1;
		dwellTime = 16'h0000;
		integralTime = 8'h00;
		clr = 1'b0;
		sys_rst = 1'b1;
		void'($urandom(48439));
		// Hysteresis edges, high on one channel and low on the other
		cf[0].func = FN_IN1_HIGH;
		cf[1].func = FN_IN1_LOW;
		cf[0].level = 16'sh0064;
		cf[1].level = 16'sh0064;
		cf[0].hysteresis = 16'sh0005;
		cf[1].hysteresis = 16'sh0005;
		do_reset();
		foreach (vals[i]) begin
			pr.pv1 = afl_val_t'(vals[i]);
			settle("hysteresis edge");
		end
		$display("test hysteresis done");
		// Every process function in every mode, each batch after a fresh power-up
		for (int f = 1; f < 13; f++) begin
			for (int m = 0; m < 4; m++) begin
				for (int i = 0; i < 2; i++) begin
					cf[i].func = afl_func_e'(i ? 13 - f : f);
					cf[i].mode = afl_mode_e'(i ? 3 - m : m);
					cf[i].level = rv(50);
					cf[i].hysteresis = afl_val_t'($urandom_range(10));
					cf[i].deviation = afl_val_t'($urandom_range(30));
				end
				do_reset();
				for (int s = 0; s < 12; s++) begin
					pr.pv1 = rv(100);
					pr.pv2 = rv(100);
					pr.setpoint = rv(50);
					pr.mvLevel = 10'($urandom_range(1000));
					clr = ($urandom_range(3) == 0);
					settle("random alarm");
				end
			end
		end
		clr = 1'b0;
		$display("test functions and modes done");
		// Channel two is silent without alarm duty, loop failure included
		// Channel one idle, so nothing latched from stale inputs leaks into the checks
		cf[0] = '0;
		cf[1].func = FN_LOOP_FAILURE;
		cf[1].mode = MODE_PLAIN;
		pr.mvLevel = MV_MAX;
		duty = 1'b0;
		do_reset();
		repeat (40) @(posedge clk);
		#1;
		`CHK(alarm2Out, 1'b0, "loop alarm without duty")
		cf[1].func = FN_IN1_HIGH;
		cf[1].level = 16'sh0000;
		cf[1].hysteresis = 16'sh0000;
		pr.pv1 = 16'sh0032;
		settle("no duty");
		duty = 1'b1;
		settle("duty on");
		$display("test output two duty done");
		// Heater break: low alarm on the current input, 13.0 A trip, 0.1 A hysteresis
		cf[0].func = FN_IN2_LOW;
		cf[0].level = 16'sh0082;
		cf[0].hysteresis = 16'sh0001;
		// Current held steady over each check, as a long output cycle gives
		pr.pv2 = 16'sh00b6;
		settle("heater healthy");
		pr.pv2 = 16'sh005b;
		settle("heater broken");
		$display("test heater break done");
		// Dwell timer: idle before set point, runs, relay holds after expiry
		cf[0] = '0;
		cf[1] = '0;
		cf[0].func = FN_DWELL_TIMER;
		cf[0].mode = MODE_HOLD;
		pr.setpoint = 16'sh0000;
		pr.pv1 = -16'sh0032;
		dwellTime = 16'h0001;
		do_reset();
		repeat (10) @(posedge clk);
		#1;
		`CHK(alarm1Out, 1'b0, "timer before set point")
		`CHK(configError, 1'b0, "single timer flagged")
		pr.pv1 = 16'sh000a;
		repeat (100) @(posedge clk);
		#1;
		`CHK(alarm1Out, 1'b0, "timer expired too soon")
		dwellTime = 16'h0000;
		k = 0;
		while (alarm1Out !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (alarm1Out !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t dwell timer never expired", $time);
			close_out();
		end
		pr.pv1 = -16'sh0032;
		repeat (6) @(posedge clk);
		#1;
		`CHK(alarm1Out, 1'b1, "timer relay dropped")
		cf[1].func = FN_DWELL_TIMER;
		repeat (3) @(posedge clk);
		#1;
		`CHK(configError, 1'b1, "double timer not flagged")
		cf[1].func = FN_NONE;
		repeat (3) @(posedge clk);
		#1;
		`CHK(configError, 1'b0, "flag stuck")
		$display("test dwell timer done");
		close_out();
	end
endmodule
